// [verilog/adc_readout_regs.svh]
// register offsets, field positions, reset values and counts of the serial readout block
`ifndef ADC_READOUT_REGS_SVH
`define ADC_READOUT_REGS_SVH

// byte addresses of the apb registers
`define ADC_OFS_CONTROL          8'h00
`define ADC_OFS_STATUS           8'h04
`define ADC_OFS_TIMING           8'h08

// control register fields
`define ADC_CTRL_SOFT_START      0

// status register fields
`define ADC_STAT_BUSY            0
`define ADC_STAT_OSR_LSB         1
`define ADC_STAT_OSR_ACTIVE_LSB  4
`define ADC_STAT_SERIAL_ACTIVE   7
`define ADC_STAT_COUNT_LSB       16

// timing register: pclk cycles per converter sample
`define ADC_TIMING_RESET         16'h0040
`define ADC_TIMING_MIN           16'h0001

// serial word and channel grouping
`define ADC_BITS_PER_WORD        5'h10
`define ADC_LAST_BIT_FALL        5'h0F
`define ADC_FIRST_CHANNEL        3'h0
`define ADC_SECOND_GROUP         3'h4
`define ADC_LAST_CHANNEL         3'h7
`define ADC_OSR_INVALID          3'h7

// synchroniser reset image: serial clock and select idle high
`define ADC_PIN_RESET            9'h180

`endif

// [verilog/adc_readout_pkg.sv]
// types shared by the serial readout block and its testbench
package adc_readout_pkg;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_SAMPLE,
    CONV_STORE
  } conv_phase_t;

  // external pins, bundled for the synchroniser
  typedef struct packed {
    logic       sclk;
    logic       select_n;
    logic       start_one;
    logic       start_two;
    logic       format;
    logic       byte_mode;
    logic [2:0] osr;
  } pin_bus_t;

  typedef logic signed [15:0] sample_t;
  typedef logic signed [21:0] acc_t;

  typedef struct packed {
    conv_phase_t      phase;
    logic             busy;
    logic [2:0]       osr;
    logic [2:0]       osr_active;
    logic [6:0]       sample_idx;
    logic [15:0]      wait_cnt;
    logic [2:0]       store_ch;
    acc_t [7:0]       acc;
    logic             armed_one;
    logic             armed_two;
    logic             start_one_d;
    logic             start_two_d;
    logic             soft_start;
    logic [15:0]      sample_cycles;
    logic [15:0]      conv_count;
    logic             sclk_d;
    logic             select_n_d;
    logic             active;
    logic [4:0]       fall_cnt;
    logic [15:0]      shift_a;
    logic [15:0]      shift_b;
    logic [2:0]       ptr_a;
    logic [2:0]       ptr_b;
    logic             flag;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } readout_state_t;

endpackage : adc_readout_pkg

// [verilog/pin_sync.sv]
// three-stage synchroniser with agreement filter for asynchronous pins
module pin_sync #(
  parameter int               WIDTH       = 9,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  typedef struct packed {
    logic [WIDTH-1:0] ff1;
    logic [WIDTH-1:0] ff2;
    logic [WIDTH-1:0] ff3;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t      s;
  sync_state_t      next_s;
  logic [WIDTH-1:0] agreed;

  // a bit changes only once stages two and three agree; stage one feeds stage two only;
  // the agreed value leaves at once, so a pin edge costs three cycles rather than four
  always_comb begin
    next_s     = s;
    next_s.ff1 = pin_in;
    next_s.ff2 = s.ff1;
    next_s.ff3 = s.ff2;
    agreed     = s.stable;
    for (int i = 0; i < WIDTH; i++) begin
      if (s.ff2[i] == s.ff3[i]) begin
        agreed[i] = s.ff3[i];
      end
    end
    next_s.stable = agreed;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= {RESET_VALUE, RESET_VALUE, RESET_VALUE, RESET_VALUE};
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign pin_out = agreed;

endmodule // pin_sync

// [verilog/result_memory.sv]
// channel result store: one write port, two registered read ports
module result_memory #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16,
  parameter int AW    = 3
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr_a,
  input  wire logic [AW-1:0]    raddr_b,
  output logic      [WIDTH-1:0] rdata_a,
  output logic      [WIDTH-1:0] rdata_b
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] cells;
    logic [WIDTH-1:0]            rd_a;
    logic [WIDTH-1:0]            rd_b;
  } mem_state_t;

  mem_state_t s;
  mem_state_t next_s;

  // reads return the old word when the same cell is written in that cycle
  always_comb begin
    next_s      = s;
    next_s.rd_a = s.cells[raddr_a];
    next_s.rd_b = s.cells[raddr_b];
    if (we) begin
      next_s.cells[waddr] = wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign rdata_a = s.rd_a;
  assign rdata_b = s.rd_b;

endmodule // result_memory

// [verilog/adc_serial_readout_osr.sv]
// eight-channel converter result store with serial readout and oversampling average
//
// Our own choices: the APB slave port and the register addresses.
`include "adc_readout_regs.svh"

// Contract
// R1 - host picks serial mode: format high, byte low
// R2 - select high: outputs off, clock ignored
// R3 - select fall: outputs on, msb presented
// R4 - remaining fifteen bits shift on rising edges
// R5 - sixteen clocks per channel, ascending channels
// R6 - host may frame per word or whole
// R7 - first line: channels 1-4, then 5-8
// R8 - second line: channels 5-8, then 1-4
// R9 - flag high at channel one, low 16th fall
// R10 - flag also marks channel five on line two
// R11 - single line needs 128 clocks
// R12 - both lines need 64 clocks
// R13 - read while busy returns previous sample
// R14 - host ends reads before busy falls
// R15 - ratio pins captured at busy fall
// R16 - host drives both starts together
// R17 - busy time grows with ratio
// R18 - averaging filter before storing results
// R19 - results load as busy falls
// R20 - both lines shift on same edges
// R21 - pointers restart at result reload
module adc_serial_readout_osr (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire logic                           ce,
  input  wire logic [7:0]                     paddr,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  input  wire logic                           serial_clock,
  input  wire logic                           select_n,
  input  wire logic                           interface_format_select,
  input  wire logic                           byte_mode_select,
  input  wire logic [2:0]                     oversample_ratio_pins,
  input  wire logic                           convert_start_group_one,
  input  wire logic                           convert_start_group_two,
  input  wire adc_readout_pkg::sample_t [7:0] sample_in,
  output logic                                serial_out_first,
  output logic                                serial_out_first_oe,
  output logic                                serial_out_second,
  output logic                                serial_out_second_oe,
  output logic                                first_channel_flag,
  output logic                                first_channel_flag_oe,
  output logic                                busy
);

  adc_readout_pkg::readout_state_t s;
  adc_readout_pkg::readout_state_t next_s;
  adc_readout_pkg::pin_bus_t       pin_raw;
  adc_readout_pkg::pin_bus_t       pins;
  adc_readout_pkg::acc_t           avg_value;
  logic [15:0]                     rd_a;
  logic [15:0]                     rd_b;
  logic                            mem_we;
  logic [15:0]                     mem_wdata;
  logic                            serial_mode;
  logic                            sclk_rise;
  logic                            sclk_fall;
  logic                            sel_fall;
  logic [6:0]                      last_sample;

  assign pin_raw = {serial_clock, select_n, convert_start_group_one, convert_start_group_two,
                    interface_format_select, byte_mode_select, oversample_ratio_pins};

  pin_sync #(
    .WIDTH       (9),
    .RESET_VALUE (`ADC_PIN_RESET)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .pin_in  (pin_raw),
    .pin_out (pins)
  );

  result_memory #(
    .DEPTH (8),
    .WIDTH (16),
    .AW    (3)
  ) u_result_memory (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .we      (mem_we),
    .waddr   (s.store_ch),
    .wdata   (mem_wdata),
    .raddr_a (s.ptr_a),
    .raddr_b (s.ptr_b),
    .rdata_a (rd_a),
    .rdata_b (rd_b)
  );

  // edge finding on the filtered pins; serial readout only in serial format
  assign serial_mode = pins.format && !pins.byte_mode; // [R1]
  assign sclk_rise   = pins.sclk && !s.sclk_d;
  assign sclk_fall   = !pins.sclk && s.sclk_d;
  assign sel_fall    = !pins.select_n && s.select_n_d;
  assign last_sample = 7'((7'h01 << s.osr_active) - 7'h01);

  // averaging filter: sum of 2^ratio samples divided by arithmetic shift
  assign avg_value = s.acc[s.store_ch] >>> s.osr_active; // [R18]
  assign mem_wdata = avg_value[15:0];
  assign mem_we    = (s.phase == adc_readout_pkg::CONV_STORE); // [R13] [R19]

  always_comb begin
    logic        set_soft;
    logic        consume;
    logic [31:0] status_word;
    set_soft           = 1'b0;
    consume            = 1'b0;
    status_word        = '0;
    next_s             = s;
    next_s.sclk_d      = pins.sclk;
    next_s.select_n_d  = pins.select_n;
    next_s.start_one_d = pins.start_one;
    next_s.start_two_d = pins.start_two;
    next_s.pready      = 1'b0;
    next_s.pslverr     = 1'b0;

    status_word[`ADC_STAT_BUSY]                = s.busy;
    status_word[`ADC_STAT_OSR_LSB +: 3]        = s.osr;
    status_word[`ADC_STAT_OSR_ACTIVE_LSB +: 3] = s.osr_active;
    status_word[`ADC_STAT_SERIAL_ACTIVE]       = s.active;
    status_word[`ADC_STAT_COUNT_LSB +: 16]     = s.conv_count;

    // apb slave: one wait state, pready raised in the second access cycle
    if (psel && penable && !s.pready) begin
      next_s.pready = 1'b1;
      case (paddr)
        `ADC_OFS_CONTROL: next_s.prdata = 32'h0000_0000;
        `ADC_OFS_STATUS:  next_s.prdata = status_word;
        `ADC_OFS_TIMING:  next_s.prdata = {16'h0000, s.sample_cycles};
        default: begin
          next_s.pslverr = 1'b1;
          next_s.prdata  = 32'h0000_0000;
        end
      endcase
    end

    // writes land at the completion edge, while address and data are still held
    if (psel && penable && s.pready && pwrite) begin
      set_soft = (paddr == `ADC_OFS_CONTROL) && pwdata[`ADC_CTRL_SOFT_START];
      if (paddr == `ADC_OFS_TIMING) begin
        // zero would stretch each sample to 65536 cycles as the 16-bit compare wraps, so it is lifted to one
        next_s.sample_cycles = (pwdata[15:0] == 16'h0000) ? `ADC_TIMING_MIN : pwdata[15:0];
      end
    end

    // conversion sequencer; memory is untouched until the store phase
    case (s.phase)
      adc_readout_pkg::CONV_IDLE: begin
        if (pins.start_one && !s.start_one_d) begin
          next_s.armed_one = 1'b1;
        end
        if (pins.start_two && !s.start_two_d) begin
          next_s.armed_two = 1'b1;
        end
        if ((next_s.armed_one && next_s.armed_two) || s.soft_start) begin
          consume           = 1'b1;
          next_s.armed_one  = 1'b0;
          next_s.armed_two  = 1'b0;
          next_s.phase      = adc_readout_pkg::CONV_SAMPLE;
          next_s.busy       = 1'b1;
          next_s.osr_active = s.osr;
          next_s.sample_idx = 7'h00;
          next_s.wait_cnt   = 16'h0000;
          next_s.acc        = '0;
        end
      end
      adc_readout_pkg::CONV_SAMPLE: begin
        // busy spans 2^ratio sample periods plus eight store cycles, so it lengthens with the ratio
        next_s.wait_cnt = s.wait_cnt + 16'h0001; // [R17]
        if (s.wait_cnt == s.sample_cycles - 16'h0001) begin
          next_s.wait_cnt = 16'h0000;
          for (int i = 0; i < 8; i++) begin
            next_s.acc[i] = s.acc[i] + adc_readout_pkg::acc_t'(sample_in[i]); // [R18]
          end
          next_s.sample_idx = s.sample_idx + 7'h01;
          if (s.sample_idx == last_sample) begin
            next_s.phase    = adc_readout_pkg::CONV_STORE;
            next_s.store_ch = `ADC_FIRST_CHANNEL;
          end
        end
      end
      adc_readout_pkg::CONV_STORE: begin
        // results land in the last eight busy cycles, just before busy falls
        next_s.store_ch = s.store_ch + 3'h1; // [R19]
      end
      default: begin
        next_s.phase = adc_readout_pkg::CONV_IDLE;
        next_s.busy  = 1'b0;
      end
    endcase

    // a request arriving while one is consumed is kept: set wins
    next_s.soft_start = (s.soft_start && !consume) || set_soft;

    // serial readout; both lines move on the same clock edges
    if (pins.select_n || !serial_mode) begin
      next_s.active = 1'b0; // [R2]
      next_s.flag   = 1'b0;
    end else if (sel_fall) begin
      next_s.active   = 1'b1; // [R3]
      next_s.shift_a  = rd_a;
      next_s.shift_b  = rd_b;
      next_s.fall_cnt = 5'h00;
      // line two sits four channels on, so channel five pairs with channel one
      next_s.flag     = (s.ptr_a == `ADC_FIRST_CHANNEL); // [R9] [R10]
    end else if (s.active) begin
      if (sclk_fall && s.fall_cnt != `ADC_BITS_PER_WORD) begin
        next_s.fall_cnt = s.fall_cnt + 5'h01;
        if (s.fall_cnt == `ADC_LAST_BIT_FALL) begin
          next_s.flag  = 1'b0; // [R9]
          next_s.ptr_a = s.ptr_a + 3'h1; // [R5] [R7] [R20]
          next_s.ptr_b = s.ptr_b + 3'h1; // [R8] [R20]
        end
      end
      if (sclk_rise) begin
        if (s.fall_cnt == `ADC_BITS_PER_WORD) begin
          next_s.shift_a  = rd_a; // [R5]
          next_s.shift_b  = rd_b;
          next_s.fall_cnt = 5'h00;
          next_s.flag     = (s.ptr_a == `ADC_FIRST_CHANNEL); // [R9] [R10]
        end else begin
          next_s.shift_a = {s.shift_a[14:0], 1'b0}; // [R4] [R20]
          next_s.shift_b = {s.shift_b[14:0], 1'b0};
        end
      end
    end

    // last store cycle: busy falls, ratio pins latched, pointers rewound
    if (s.phase == adc_readout_pkg::CONV_STORE && s.store_ch == `ADC_LAST_CHANNEL) begin
      next_s.phase      = adc_readout_pkg::CONV_IDLE;
      next_s.busy       = 1'b0;
      next_s.osr        = (pins.osr == `ADC_OSR_INVALID) ? 3'h0 : pins.osr; // [R15]
      next_s.ptr_a      = `ADC_FIRST_CHANNEL; // [R21]
      next_s.ptr_b      = `ADC_SECOND_GROUP; // [R21]
      next_s.conv_count = s.conv_count + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s               <= '0;
      s.phase         <= adc_readout_pkg::CONV_IDLE;
      s.sample_cycles <= `ADC_TIMING_RESET;
      s.ptr_b         <= `ADC_SECOND_GROUP;
      s.sclk_d        <= 1'b1;
      s.select_n_d    <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign prdata                = s.prdata;
  assign pready                = s.pready;
  assign pslverr               = s.pslverr;
  assign serial_out_first      = s.shift_a[15];
  assign serial_out_second     = s.shift_b[15];
  assign serial_out_first_oe   = s.active;
  assign serial_out_second_oe  = s.active;
  assign first_channel_flag    = s.flag;
  assign first_channel_flag_oe = s.active;
  assign busy                  = s.busy;

  // helper: length of the current busy period, for the timing check below
  logic [23:0] busy_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_len <= 24'h000000;
    end else if (ce) begin
      busy_len <= s.busy ? busy_len + 24'h000001 : 24'h000000;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !ce);

  property p_idle_off;
    pins.select_n |=> !serial_out_first_oe && !first_channel_flag_oe && !first_channel_flag;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("outputs active with select high"); // [R2]

  property p_msb_first;
    (sel_fall && serial_mode) |=> serial_out_first_oe && s.shift_a == $past(rd_a);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("msb not presented at select fall"); // [R3]

  property p_shift;
    (s.active && sclk_rise && !sel_fall && !pins.select_n && serial_mode
      && s.fall_cnt != `ADC_BITS_PER_WORD)
      |=> s.shift_a == {$past(s.shift_a[14:0]), 1'b0} && s.shift_b == {$past(s.shift_b[14:0]), 1'b0};
  endproperty
  a_shift: assert property (p_shift) else $error("serial lines did not shift together"); // [R4]

  property p_advance;
    (s.active && sclk_fall && s.fall_cnt == `ADC_LAST_BIT_FALL && !pins.select_n && serial_mode
      && !mem_we) |=> s.ptr_a == 3'($past(s.ptr_a) + 3'h1) && !first_channel_flag;
  endproperty
  a_advance: assert property (p_advance) else $error("word end did not advance channel"); // [R5]

  property p_group_offset;
    s.ptr_b == 3'(s.ptr_a + `ADC_SECOND_GROUP);
  endproperty
  a_group_offset: assert property (p_group_offset) else $error("line two not four ahead"); // [R8]

  property p_reload;
    $fell(s.busy) |-> s.ptr_a == `ADC_FIRST_CHANNEL && s.osr == $past(pins.osr == 3'h7 ? 3'h0 : pins.osr);
  endproperty
  a_reload: assert property (p_reload) else $error("busy fall did not rewind or latch"); // [R15]

  property p_store_tail;
    $rose(mem_we) |-> mem_we [*8] ##1 !s.busy;
  endproperty
  a_store_tail: assert property (p_store_tail) else $error("store phase not eight cycles"); // [R19]

  property p_busy_length;
    $fell(s.busy) |-> $past(busy_len) ==
      24'((24'h000001 << $past(s.osr_active)) * 24'($past(s.sample_cycles)) + 24'h000007);
  endproperty
  a_busy_length: assert property (p_busy_length) else $error("busy length wrong for ratio"); // [R17]

  property p_hold_while_sampling;
    (s.phase == adc_readout_pkg::CONV_SAMPLE) |=> $stable(u_result_memory.s.cells);
  endproperty
  a_hold_while_sampling: assert property (p_hold_while_sampling) else $error("results changed mid conversion"); // [R13]

endmodule // adc_serial_readout_osr

// [sim/serial_host_model.sv]
// host-side serial reader: drives select and serial clock, captures both data lines
module serial_host_model #(
  parameter int HALF_NS = 80
) (
  output logic      serial_clock,
  output logic      select_n,
  input  wire logic line_a,
  input  wire logic line_b,
  input  wire logic flag,
  input  wire logic oe_a,
  input  wire logic oe_b,
  input  wire logic oe_f
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [15:0] cap_a [0:7];
  logic [15:0] cap_b [0:7];
  logic        flag_start [0:7];
  logic        flag_end [0:7];
  logic        oe_seen;
  logic        oe_all;

  // serial clock idles high, select idles deasserted
  initial begin
    serial_clock = 1'b1;
    select_n = 1'b1;
  end

  // clocks with select high; the device has to ignore them
  task automatic idle_clocks(input int n);
    #7;
    repeat (n) begin
      #HALF_NS serial_clock = 1'b0;
      #HALF_NS serial_clock = 1'b1;
    end
  endtask

  // half period kept above the device's synchroniser delay, so bits settle
  task automatic read_words(input int words, input bit per_word);
    oe_seen = 1'b0;
    oe_all = 1'b1;
    #7;
    for (int w = 0; w < words; w++) begin
      if (per_word || w == 0) begin
        select_n = 1'b0;
        #(2 * HALF_NS);
      end
      for (int b = 0; b < 16; b++) begin
        #HALF_NS;
        cap_a[w] = {cap_a[w][14:0], line_a};
        cap_b[w] = {cap_b[w][14:0], line_b};
        if (b == 0) flag_start[w] = flag;
        oe_seen = oe_seen | oe_a | oe_b | oe_f;
        oe_all = oe_all & oe_a & oe_b & oe_f;
        serial_clock = 1'b0;
        #HALF_NS;
        if (b == 15) flag_end[w] = flag;
        serial_clock = 1'b1;
      end
      if (per_word || w == words - 1) begin
        #HALF_NS select_n = 1'b1;
        #(2 * HALF_NS);
      end
    end
  endtask
endmodule // serial_host_model

// [sim/adc_serial_readout_osr_test.sv]
// self-checking bench: apb setup, conversions, serial reads through the host model
`include "adc_readout_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %0t: got %h expected %h", $time, (g), (e)); end end
module adc_serial_readout_osr_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] T = 16'h0018;

  logic                           pclk = 1'b0;
  logic                           presetn = 1'b0;
  logic                           ce = 1'b1;
  logic                           psel = 1'b0;
  logic                           penable = 1'b0;
  logic                           pwrite = 1'b0;
  logic [7:0]                     paddr = 8'h00;
  logic [31:0]                    pwdata = 32'h0;
  logic [31:0]                    prdata;
  logic                           pready, pslverr, busy, busy_q = 1'b0;
  logic                           serial_clock, select_n;
  logic                           interface_format_select = 1'b1;
  logic                           byte_mode_select = 1'b0;
  logic [2:0]                     oversample_ratio_pins = 3'h0;
  logic                           convert_start_group_one = 1'b0;
  logic                           convert_start_group_two = 1'b0;
  adc_readout_pkg::sample_t [7:0] sample_in = '0;
  adc_readout_pkg::sample_t [7:0] cur, nxt;
  logic                           serial_out_first, serial_out_first_oe;
  logic                           serial_out_second, serial_out_second_oe;
  logic                           first_channel_flag, first_channel_flag_oe;
  logic [31:0]                    rd, rnd;
  logic                           er;
  integer                         seed = 32'h9EB6;
  int compares = 0, bad_count = 0, rd_off = 0, run_len = 0, last_len = 0;
  int cur_r = -1, next_r = 0;

  always #10 pclk = ~pclk;

  adc_serial_readout_osr adc_serial_readout_osr_inst (.pclk, .presetn, .ce, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .serial_clock, .select_n,
    .interface_format_select, .byte_mode_select, .oversample_ratio_pins,
    .convert_start_group_one, .convert_start_group_two, .sample_in, .serial_out_first,
    .serial_out_first_oe, .serial_out_second, .serial_out_second_oe, .first_channel_flag,
    .first_channel_flag_oe, .busy);

  serial_host_model host (.serial_clock(serial_clock), .select_n(select_n),
    .line_a(serial_out_first), .line_b(serial_out_second), .flag(first_channel_flag),
    .oe_a(serial_out_first_oe), .oe_b(serial_out_second_oe), .oe_f(first_channel_flag_oe));

  // busy length in pclk cycles, taken from pre-edge values
  always @(posedge pclk) begin
    busy_q <= busy;
    if (busy === 1'b1) run_len <= run_len + 1;
    else if (busy_q === 1'b1) begin
      last_len <= run_len;
      run_len <= 0;
    end
  end

  // one apb transfer; pready looked at on the rising edge, request held until then
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1; paddr <= a; pwrite <= wr; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) bad_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // new random samples, both starts together, then next ratio while busy
  task automatic start_conv();
    int n;
    for (int i = 0; i < 8; i++) begin rnd = $random(seed); nxt[i] = rnd[15:0]; end
    @(posedge pclk);
    sample_in <= nxt;
    convert_start_group_one <= 1'b1;
    convert_start_group_two <= 1'b1;
    n = 0;
    do begin @(posedge pclk); #1; n++; end while (busy !== 1'b1 && n < 40);
    `CHK(busy, 1'b1)
    @(posedge pclk);
    convert_start_group_one <= 1'b0;
    convert_start_group_two <= 1'b0;
    rnd = $random(seed);
    next_r = int'(rnd[2:0]);
    oversample_ratio_pins <= rnd[2:0];
  endtask

  // constant samples make the average equal the sample itself
  task automatic finish_conv();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin @(posedge pclk); #1; n++; end
    if (busy !== 1'b0) bad_count++;
    @(posedge pclk); #1;
    if (cur_r >= 0) `CHK(last_len, ((cur_r == 7 ? 1 : 1 << cur_r) * T) + 8)
    cur = nxt;
    rd_off = 0;
    cur_r = next_r;
  endtask

  task automatic rd_chk(input int words, input bit per_word);
    int c;
    host.read_words(words, per_word);
    for (int w = 0; w < words; w++) begin
      c = (rd_off + w) % 8;
      `CHK(host.cap_a[w], cur[c])
      `CHK(host.cap_b[w], cur[(c + 4) % 8])
      `CHK(host.flag_start[w], c == 0)
      `CHK(host.flag_end[w], 1'b0)
    end
    `CHK(host.oe_all, 1'b1)
    rd_off = (rd_off + words) % 8;
    repeat (8) @(posedge pclk);
    `CHK({serial_out_first_oe, serial_out_second_oe, first_channel_flag_oe}, 3'h0)
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, `ADC_OFS_TIMING, 32'h0);
    `CHK(rd[15:0], `ADC_TIMING_RESET)
    apb(1'b1, `ADC_OFS_TIMING, 32'h0);
    apb(1'b0, `ADC_OFS_TIMING, 32'h0);
    `CHK(rd[15:0], `ADC_TIMING_MIN)
    apb(1'b0, 8'h0C, 32'h0);
    `CHK(er, 1'b1)
    apb(1'b1, `ADC_OFS_TIMING, {16'h0, T});
    host.idle_clocks(4);
    `CHK(serial_out_first_oe, 1'b0)
    start_conv();
    apb(1'b0, `ADC_OFS_STATUS, 32'h0);
    `CHK(rd[`ADC_STAT_BUSY], 1'b1)
    finish_conv();
    // reads after busy falls, mixing line count and framing
    for (int k = 0; k < 6; k++) begin
      start_conv();
      finish_conv();
      rd_chk(k % 3 == 1 ? 4 : 8, k % 3 != 0);
    end
    // long conversion so a framed read fits inside busy
    start_conv();
    @(posedge pclk);
    oversample_ratio_pins <= 3'h6;
    next_r = 6;
    finish_conv();
    rd_chk(3, 1'b1);
    start_conv();
    rd_chk(4, 1'b1);
    finish_conv();
    rd_chk(8, 1'b0);
    // software start: busy must be up a few cycles after the write completes
    apb(1'b1, `ADC_OFS_CONTROL, 32'h1);
    repeat (3) @(posedge pclk);
    `CHK(busy, 1'b1)
    finish_conv();
    rd_chk(4, 1'b0);
    // parallel and byte selections leave the serial lines off
    for (int m = 0; m < 2; m++) begin
      @(posedge pclk);
      {interface_format_select, byte_mode_select} <= (m == 0) ? 2'h0 : 2'h3;
      repeat (6) @(posedge pclk);
      host.read_words(1, 1'b1);
      `CHK(host.oe_seen, 1'b0)
    end
    conclude();
  end

  // guard against a hang: well beyond the full sequence
  initial begin
    #1_000_000;
    bad_count++;
    conclude();
  end
endmodule // adc_serial_readout_osr_test
